// file: rtl/tcec_accum.v
// event accumulator: adds an increment each cycle, clear has priority.
// assumes: one clock, asynchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none
`include "tcec_defs.vh"

module tcec_accum #(
  parameter CNT_W = 48,
  parameter INC_W = 9
) (
  // clock and reset
  input  wire             mclk,
  input  wire             resetn,
  // control
  input  wire             clear,
  input  wire [INC_W-1:0] inc,
  // state
  output wire [CNT_W-1:0] count,
  output wire             wrap
);

  reg  [CNT_W-1:0] count_r;
  wire [CNT_W:0]   sum_nxt;

  assign sum_nxt = {1'b0, count_r} + {{(CNT_W+1-INC_W){1'b0}}, inc};
  assign count   = count_r;
  // wrap is lost when a clear lands in the same cycle
  assign wrap    = sum_nxt[CNT_W] & ~clear;

  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      count_r <= {CNT_W{1'b0}};
    end else if (clear) begin
      count_r <= {CNT_W{1'b0}};
    end else begin
      count_r <= sum_nxt[CNT_W-1:0];
    end
  end

endmodule // tcec_accum
`default_nettype wire

// file: rtl/tcec_defs.vh
// constants for the transgress credit event counter: register map, field
// positions, reset values and event codes.
// assumes: included by bare name from every design file of the block.
`ifndef TCEC_DEFS_VH
`define TCEC_DEFS_VH

// ----------------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------------
`define TCEC_ADDR_CTRL_LO    12'h000
`define TCEC_ADDR_CTRL_HI    12'h004
`define TCEC_ADDR_COUNT_LO   12'h008
`define TCEC_ADDR_COUNT_HI   12'h00C
`define TCEC_ADDR_STATUS     12'h010

// ----------------------------------------------------------------------
// control and status fields
// ----------------------------------------------------------------------
`define TCEC_EV_LSB          0
`define TCEC_EV_MSB          7
`define TCEC_UMASK_LSB       8
`define TCEC_UMASK_MSB       15
`define TCEC_CLR_BIT         17
`define TCEC_EN_BIT          22
`define TCEC_XSEL_BIT        24
`define TCEC_STAT_OVF_BIT    0
`define TCEC_STAT_MATCH_BIT  1
`define TCEC_CTRL_LO_WMASK   32'h0040FFFF
`define TCEC_CTRL_HI_WMASK   32'h01000000
`define TCEC_CTRL_LO_RESET   32'h00000000
`define TCEC_CTRL_HI_RESET   32'h00000000

// ----------------------------------------------------------------------
// event codes
// ----------------------------------------------------------------------
`define TCEC_EV_A1_AD_TAKEN_LO  8'h84
`define TCEC_EV_A1_AD_TAKEN_HI  8'h85
`define TCEC_EV_A1_AD_HELD_LO   8'h86
`define TCEC_EV_A1_AD_HELD_HI   8'h87
`define TCEC_EV_A0_BL_TAKEN_LO  8'h88
`define TCEC_EV_A0_BL_TAKEN_HI  8'h89
`define TCEC_EV_A0_BL_HELD_LO   8'h8A
`define TCEC_EV_A0_BL_HELD_HI   8'h8B
`define TCEC_EV_A1_BL_TAKEN_LO  8'h8C
`define TCEC_EV_A1_BL_TAKEN_HI  8'h8D

// ----------------------------------------------------------------------
// source selector codes and geometry
// ----------------------------------------------------------------------
`define TCEC_SRC_NONE        3'h0
`define TCEC_SRC_A0_BL_TAKE  3'h1
`define TCEC_SRC_A0_BL_HELD  3'h2
`define TCEC_SRC_A1_AD_TAKE  3'h3
`define TCEC_SRC_A1_AD_HELD  3'h4
`define TCEC_SRC_A1_BL_TAKE  3'h5
`define TCEC_TGR_NUM         16
`define TCEC_LANES           8

`endif

// file: rtl/tcec_mask_sum.v
// masked sum of eight per-transgress credit counts.
// assumes: inputs are stable within the cycle; purely combinational.
`timescale 1ns/100ps
`default_nettype none
`include "tcec_defs.vh"

module tcec_mask_sum #(
  parameter LANES = `TCEC_LANES,
  parameter W     = 6
) (
  // lane data and enables
  input  wire [LANES*W-1:0] lane_data,
  input  wire [LANES-1:0]   lane_en,
  // result
  output reg  [W+2:0]       sum
);

  wire [LANES*W-1:0] gated;
  integer            k;

  genvar g;
  generate
    for (g = 0; g < LANES; g = g + 1) begin : g_gate
      assign gated[g*W +: W] = lane_data[g*W +: W] & {W{lane_en[g]}};
    end
  endgenerate

  // a zero enable vector leaves the sum at zero
  always @* begin
    sum = {(W+3){1'b0}};
    for (k = 0; k < LANES; k = k + 1) begin
      sum = sum + {3'h0, gated[k*W +: W]};
    end
  end

endmodule // tcec_mask_sum
`default_nettype wire

// file: rtl/tcec_top.v
// transgress credit event counter: apb registers, event decode and
// per-transgress credit accumulation.
// assumes: credit inputs come from mesh_stop logic on mclk; apb on mclk.
//
// Notes on behaviour
// - 0x88 sums agent0 BL taken, transgress 0-7
// - 0x89 sums agent0 BL taken, transgress 8-15
// - 0x8A sums agent0 BL held, transgress 0-7
// - 0x8B sums agent0 BL held, transgress 8-15
// - 0x84 sums agent1 AD taken, transgress 0-7
// - 0x85 sums agent1 AD taken, transgress 8-15
// - 0x86 sums agent1 AD held, transgress 0-7
// - 0x87 sums agent1 AD held, transgress 8-15
// - 0x8C sums agent1 BL taken, transgress 0-7
// - 0x8D sums agent1 BL taken, transgress 8-15
// - taken events add whole per-cycle count
// - held events add occupancy every cycle
//
// The APB interface to the registers and the register addresses were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "tcec_defs.vh"

module tcec_top #(
  parameter CNT_W = 48,
  parameter ACQ_W = 3,
  parameter OCC_W = 6
) (
  // clock and reset
  input  wire                          mclk,
  input  wire                          resetn,
  // apb slave
  input  wire                          psel,
  input  wire                          penable,
  input  wire                          pwrite,
  input  wire [11:0]                   paddr,
  input  wire [31:0]                   pwdata,
  input  wire [3:0]                    pstrb,
  output wire [31:0]                   prdata,
  output wire                          pready,
  output wire                          pslverr,
  // per-transgress credit counts from mesh_stop
  input  wire [`TCEC_TGR_NUM*ACQ_W-1:0] agent0_bl_credit_taken,
  input  wire [`TCEC_TGR_NUM*OCC_W-1:0] agent0_bl_credit_held,
  input  wire [`TCEC_TGR_NUM*ACQ_W-1:0] agent1_ad_credit_taken,
  input  wire [`TCEC_TGR_NUM*OCC_W-1:0] agent1_ad_credit_held,
  input  wire [`TCEC_TGR_NUM*ACQ_W-1:0] agent1_bl_credit_taken,
  // status
  output wire                          count_overflow
);

  localparam TN    = `TCEC_TGR_NUM;
  localparam LN    = `TCEC_LANES;
  localparam INC_W = OCC_W + 3;

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  reg  [31:0]       ctrl_lo_r;
  reg  [31:0]       ctrl_hi_r;
  reg  [31:0]       prdata_r;
  reg               pslverr_r;
  reg               ovf_r;
  reg  [31:0]       hi_snap_r;
  reg  [31:0]       rd_nxt;
  reg               err_nxt;
  reg  [2:0]        sel_src;
  reg               sel_hi;
  reg  [TN*OCC_W-1:0] src_vec;

  wire [31:0]       wmask;
  wire              setup;
  wire              access;
  wire              wr;
  wire              wr_ctrl_lo;
  wire              wr_ctrl_hi;
  wire              wr_status;
  wire              rd_count_lo;
  wire [7:0]        ev_code;
  wire [7:0]        umask;
  wire              cnt_en;
  wire              xsel;
  wire              counting;
  wire              clear;
  wire              ovf_clr;
  wire [TN*OCC_W-1:0] a0bl_take_x;
  wire [TN*OCC_W-1:0] a1ad_take_x;
  wire [TN*OCC_W-1:0] a1bl_take_x;
  wire [LN*OCC_W-1:0] slice;
  wire [INC_W-1:0]  lane_sum;
  wire [INC_W-1:0]  inc;
  wire [CNT_W-1:0]  count;
  wire [63:0]       count_x;
  wire              wrap;

  // ----------------------------------------------------------------------
  // apb handshake
  // ----------------------------------------------------------------------
  // zero wait states: read data is prepared in the setup cycle so it is
  // already in a flop when the access phase samples pready
  assign pready  = 1'b1;
  assign prdata  = prdata_r;
  assign pslverr = pslverr_r;
  assign setup   = psel & ~penable;
  assign access  = psel & penable;
  assign wr      = access & pwrite & ~pslverr_r;

  assign wr_ctrl_lo  = wr & (paddr == `TCEC_ADDR_CTRL_LO);
  assign wr_ctrl_hi  = wr & (paddr == `TCEC_ADDR_CTRL_HI);
  assign wr_status   = wr & (paddr == `TCEC_ADDR_STATUS);
  // the high word is frozen at the same edge that loads the low read data,
  // so both halves come from one counter value even across a carry
  assign rd_count_lo = setup & ~pwrite & (paddr == `TCEC_ADDR_COUNT_LO);

  genvar b;
  generate
    for (b = 0; b < 4; b = b + 1) begin : g_strb
      assign wmask[8*b +: 8] = {8{pstrb[b]}};
    end
  endgenerate

  // ----------------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------------
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ctrl_lo_r <= `TCEC_CTRL_LO_RESET;
      ctrl_hi_r <= `TCEC_CTRL_HI_RESET;
    end else begin
      if (wr_ctrl_lo) begin
        ctrl_lo_r <= (ctrl_lo_r & ~(wmask & `TCEC_CTRL_LO_WMASK)) |
                     (pwdata & wmask & `TCEC_CTRL_LO_WMASK);
      end
      if (wr_ctrl_hi) begin
        ctrl_hi_r <= (ctrl_hi_r & ~(wmask & `TCEC_CTRL_HI_WMASK)) |
                     (pwdata & wmask & `TCEC_CTRL_HI_WMASK);
      end
    end
  end

  assign ev_code = ctrl_lo_r[`TCEC_EV_MSB:`TCEC_EV_LSB];
  assign umask   = ctrl_lo_r[`TCEC_UMASK_MSB:`TCEC_UMASK_LSB];
  assign cnt_en  = ctrl_lo_r[`TCEC_EN_BIT];
  assign xsel    = ctrl_hi_r[`TCEC_XSEL_BIT];

  // the clear bit is not stored: writing one is a single-cycle pulse
  assign clear = wr_ctrl_lo & pstrb[2] & pwdata[`TCEC_CLR_BIT];

  // ----------------------------------------------------------------------
  // event decode
  // ----------------------------------------------------------------------
  always @* begin
    sel_src = `TCEC_SRC_NONE;
    sel_hi  = 1'b0;
    case (ev_code)
      `TCEC_EV_A0_BL_TAKEN_LO: begin
        sel_src = `TCEC_SRC_A0_BL_TAKE;
        sel_hi  = 1'b0;
      end
      `TCEC_EV_A0_BL_TAKEN_HI: begin
        sel_src = `TCEC_SRC_A0_BL_TAKE;
        sel_hi  = 1'b1;
      end
      `TCEC_EV_A0_BL_HELD_LO: begin
        sel_src = `TCEC_SRC_A0_BL_HELD;
        sel_hi  = 1'b0;
      end
      `TCEC_EV_A0_BL_HELD_HI: begin
        sel_src = `TCEC_SRC_A0_BL_HELD;
        sel_hi  = 1'b1;
      end
      `TCEC_EV_A1_AD_TAKEN_LO: begin
        sel_src = `TCEC_SRC_A1_AD_TAKE;
        sel_hi  = 1'b0;
      end
      `TCEC_EV_A1_AD_TAKEN_HI: begin
        sel_src = `TCEC_SRC_A1_AD_TAKE;
        sel_hi  = 1'b1;
      end
      `TCEC_EV_A1_AD_HELD_LO: begin
        sel_src = `TCEC_SRC_A1_AD_HELD;
        sel_hi  = 1'b0;
      end
      `TCEC_EV_A1_AD_HELD_HI: begin
        sel_src = `TCEC_SRC_A1_AD_HELD;
        sel_hi  = 1'b1;
      end
      `TCEC_EV_A1_BL_TAKEN_LO: begin
        sel_src = `TCEC_SRC_A1_BL_TAKE;
        sel_hi  = 1'b0;
      end
      `TCEC_EV_A1_BL_TAKEN_HI: begin
        sel_src = `TCEC_SRC_A1_BL_TAKE;
        sel_hi  = 1'b1;
      end
      default: begin
        sel_src = `TCEC_SRC_NONE;
        sel_hi  = 1'b0;
      end
    endcase
  end

  // unsupported codes, a cleared enable or a cleared extended select stop
  // counting entirely
  assign counting = cnt_en & xsel & (sel_src != `TCEC_SRC_NONE);

  // ----------------------------------------------------------------------
  // source selection
  // ----------------------------------------------------------------------
  // acquired counts are narrower than occupancy; widening them lets one
  // adder tree serve both kinds of event
  genvar g;
  generate
    for (g = 0; g < TN; g = g + 1) begin : g_ext
      assign a0bl_take_x[g*OCC_W +: OCC_W] =
        {{(OCC_W-ACQ_W){1'b0}}, agent0_bl_credit_taken[g*ACQ_W +: ACQ_W]};
      assign a1ad_take_x[g*OCC_W +: OCC_W] =
        {{(OCC_W-ACQ_W){1'b0}}, agent1_ad_credit_taken[g*ACQ_W +: ACQ_W]};
      // mask bit n is transgress n here too, whatever labels are printed
      assign a1bl_take_x[g*OCC_W +: OCC_W] =
        {{(OCC_W-ACQ_W){1'b0}}, agent1_bl_credit_taken[g*ACQ_W +: ACQ_W]};
    end
  endgenerate

  always @* begin
    src_vec = {(TN*OCC_W){1'b0}};
    case (sel_src)
      `TCEC_SRC_A0_BL_TAKE: src_vec = a0bl_take_x;
      `TCEC_SRC_A0_BL_HELD: src_vec = agent0_bl_credit_held;
      `TCEC_SRC_A1_AD_TAKE: src_vec = a1ad_take_x;
      `TCEC_SRC_A1_AD_HELD: src_vec = agent1_ad_credit_held;
      `TCEC_SRC_A1_BL_TAKE: src_vec = a1bl_take_x;
      default:              src_vec = {(TN*OCC_W){1'b0}};
    endcase
  end

  // umask bit n picks transgress n, or n plus eight for the high events
  assign slice = sel_hi ? src_vec[TN*OCC_W-1:LN*OCC_W] : src_vec[LN*OCC_W-1:0];

  // taken events add the full per-cycle count of every enabled lane; held
  // events add occupancy each cycle, so non-one-hot masks sum their lanes
  tcec_mask_sum #(
    .LANES (LN),
    .W     (OCC_W)
  ) u_sum (
    .lane_data (slice),
    .lane_en   (umask),
    .sum       (lane_sum)
  );

  assign inc = counting ? lane_sum : {INC_W{1'b0}};

  // ----------------------------------------------------------------------
  // accumulator and overflow
  // ----------------------------------------------------------------------
  tcec_accum #(
    .CNT_W (CNT_W),
    .INC_W (INC_W)
  ) u_acc (
    .mclk   (mclk),
    .resetn (resetn),
    .clear  (clear),
    .inc    (inc),
    .count  (count),
    .wrap   (wrap)
  );

  assign ovf_clr = wr_status & pstrb[0] & pwdata[`TCEC_STAT_OVF_BIT];

  // a wrap in the same cycle as the clear keeps the flag set
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ovf_r <= 1'b0;
    end else if (wrap) begin
      ovf_r <= 1'b1;
    end else if (ovf_clr) begin
      ovf_r <= 1'b0;
    end
  end

  assign count_overflow = ovf_r;
  assign count_x = {{(64-CNT_W){1'b0}}, count};

  // ----------------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------------
  // reading the low word freezes the high word, so two reads give one
  // coherent value even while the counter runs
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      hi_snap_r <= 32'h00000000;
    end else if (rd_count_lo) begin
      hi_snap_r <= count_x[63:32];
    end
  end

  always @* begin
    rd_nxt  = 32'h00000000;
    err_nxt = 1'b0;
    case (paddr)
      `TCEC_ADDR_CTRL_LO:  rd_nxt = ctrl_lo_r;
      `TCEC_ADDR_CTRL_HI:  rd_nxt = ctrl_hi_r;
      `TCEC_ADDR_COUNT_LO: rd_nxt = count_x[31:0];
      `TCEC_ADDR_COUNT_HI: rd_nxt = hi_snap_r;
      `TCEC_ADDR_STATUS: begin
        rd_nxt[`TCEC_STAT_OVF_BIT]   = ovf_r;
        rd_nxt[`TCEC_STAT_MATCH_BIT] = counting;
      end
      default:             err_nxt = 1'b1;
    endcase
  end

  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      prdata_r  <= 32'h00000000;
      pslverr_r <= 1'b0;
    end else if (setup) begin
      prdata_r  <= pwrite ? 32'h00000000 : rd_nxt;
      pslverr_r <= err_nxt;
    end else if (!psel) begin
      prdata_r  <= 32'h00000000;
      pslverr_r <= 1'b0;
    end
  end

endmodule // tcec_top
`default_nettype wire

// file: tb/tcec_mesh_stop_model.sv
// mesh_stop credit source: random or maximal per-transgress counts each cycle.
// assumes: same clock as the counter; outputs change just after the rising edge.
`timescale 1ns/100ps
`default_nettype none

module tcec_mesh_stop_model #(
  parameter int          ACQ_W = 3,
  parameter int          OCC_W = 6,
  parameter logic [31:0] SEED  = 32'h0000002E
) (
  // clock and reset
  input  wire logic                mclk,
  input  wire logic                resetn,
  // every lane at its maximum when set
  input  wire logic                max_mode,
  // per-transgress credit counts
  output var  logic [16*ACQ_W-1:0] a0_bl_tk = '0,
  output var  logic [16*OCC_W-1:0] a0_bl_hd = '0,
  output var  logic [16*ACQ_W-1:0] a1_ad_tk = '0,
  output var  logic [16*OCC_W-1:0] a1_ad_hd = '0,
  output var  logic [16*ACQ_W-1:0] a1_bl_tk = '0
);
  logic [31:0] st = SEED;
  logic [31:0] v;

  always @(posedge mclk) begin
    for (int i = 0; i < 16; i++) begin
      st = st ^ (st << 13);
      st = st ^ (st >> 17);
      st = st ^ (st << 5);
      v = !resetn ? 32'h0 : max_mode ? 32'hFFFFFFFF : st;
      a0_bl_tk[i*ACQ_W +: ACQ_W] <= v[ACQ_W-1:0];
      a1_ad_tk[i*ACQ_W +: ACQ_W] <= v[ACQ_W+3:4];
      a1_bl_tk[i*ACQ_W +: ACQ_W] <= v[ACQ_W+7:8]; // lane n is transgress n
      a0_bl_hd[i*OCC_W +: OCC_W] <= v[OCC_W+11:12];
      a1_ad_hd[i*OCC_W +: OCC_W] <= v[31:32-OCC_W];
    end
  end
endmodule // tcec_mesh_stop_model
`default_nettype wire

// file: tb/tcec_top_props.sv
// checker for the credit event counter: apb answers, control readback, idle count.
// assumes: bound to tcec_top; one clock mclk, resetn async active low.
`timescale 1ns/100ps
`default_nettype none
`include "tcec_defs.vh"

module tcec_top_props (
  // clock and reset
  input wire logic        mclk,
  input wire logic        resetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // status
  input wire logic        count_overflow
);
  // ----------------------------------------------------------------
  // shadow of the control registers
  // ----------------------------------------------------------------
  logic [31:0] lo_r;
  logic [31:0] hi_r;
  logic [31:0] last_r;
  logic        frz_r;
  logic        pdis_r;
  wire         acc    = psel && penable && pready;
  wire         setup  = psel && !penable;
  wire  [31:0] bm     = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
  wire         wr_lo  = acc && pwrite && paddr == `TCEC_ADDR_CTRL_LO;
  wire         wr_hi  = acc && pwrite && paddr == `TCEC_ADDR_CTRL_HI;
  wire         rd_cnt = acc && !pwrite && paddr == `TCEC_ADDR_COUNT_LO;
  wire         bad    = paddr[1:0] != 2'h0 || paddr > `TCEC_ADDR_STATUS;
  // idle means no increment can land, whatever the credit inputs do
  wire         dis    = !lo_r[`TCEC_EN_BIT] || !hi_r[`TCEC_XSEL_BIT] || lo_r[15:8] == 8'h00;

  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      lo_r   <= 32'h0;
      hi_r   <= 32'h0;
      last_r <= 32'h0;
      frz_r  <= 1'b0;
      pdis_r <= 1'b1;
    end else begin
      if (wr_lo)
        lo_r <= (lo_r & ~bm) | (pwdata & bm);
      if (wr_hi)
        hi_r <= (hi_r & ~bm) | (pwdata & bm);
      pdis_r <= dis;
      if (!dis || (wr_lo && pstrb[2] && pwdata[`TCEC_CLR_BIT]))
        frz_r <= 1'b0;
      else if (rd_cnt && pdis_r) begin
        frz_r  <= 1'b1;
        last_r <= prdata;
      end
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  a_ready_const:
    assert property (pready) else $error("pready low");
  a_err_refused:
    assert property (setup && bad |=> pslverr && prdata == 32'h0) else $error("bad addr");
  a_ok_mapped:
    assert property (setup && !bad |=> !pslverr) else $error("mapped addr refused");
  a_idle_quiet:
    assert property (!psel |=> prdata == 32'h0 && !pslverr) else $error("bus not quiet");
  a_lo_readback:
    assert property (setup && !pwrite && paddr == `TCEC_ADDR_CTRL_LO
                     |=> prdata == (lo_r & `TCEC_CTRL_LO_WMASK)) else $error("ctrl lo");
  a_hi_readback:
    assert property (setup && !pwrite && paddr == `TCEC_ADDR_CTRL_HI
                     |=> prdata == (hi_r & `TCEC_CTRL_HI_WMASK)) else $error("ctrl hi");
  a_status_read:
    assert property (setup && !pwrite && paddr == `TCEC_ADDR_STATUS
                     |=> prdata[0] == $past(count_overflow) && prdata[31:2] == 30'h0)
    else $error("status");
  a_idle_frozen:
    assert property (rd_cnt && frz_r |-> prdata == last_r) else $error("count moved idle");
endmodule // tcec_top_props

bind tcec_top tcec_top_props u_props (.mclk(mclk), .resetn(resetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .count_overflow(count_overflow));
`default_nettype wire

// file: tb/test_transgress_credit_event_count.sv
// testbench for the credit event counter: apb master, credit source, count model.
// assumes: tcec_top with default widths; checker attached by bind.
`timescale 1ns/100ps
`default_nettype none
`include "tcec_defs.vh"

module test_transgress_credit_event_count;
  localparam int AW = 3;
  localparam int OW = 6;
  logic             mclk    = 1'b0;
  logic             resetn  = 1'b0;
  logic             psel    = 1'b0;
  logic             penable = 1'b0;
  logic             pwrite  = 1'b0;
  logic [11:0]      paddr   = 12'h000;
  logic [31:0]      pwdata  = 32'h0;
  logic [3:0]       pstrb   = 4'hF;
  logic             max_mode = 1'b0;
  wire  [31:0]      prdata;
  wire              pready;
  wire              pslverr;
  wire  [16*AW-1:0] a0_bl_tk, a1_ad_tk, a1_bl_tk;
  wire  [16*OW-1:0] a0_bl_hd, a1_ad_hd;
  logic [31:0]      ctl = 32'h0, rs = 32'h0000002E, q, x;
  logic             xsel = 1'b0, e;
  logic [7:0]       um;
  logic [47:0]      exp_cnt = 48'h0, snap = 48'h0;
  int               errors = 0, n_tests = 0;
  // event codes, two unsupported last
  logic [7:0] codes [12] = '{8'h84, 8'h85, 8'h86, 8'h87, 8'h88, 8'h89, 8'h8A, 8'h8B,
                             8'h8C, 8'h8D, 8'h83, 8'h8E};
  wire              wacc = psel && penable && pready && pwrite;

  always #2.5 mclk = ~mclk;

  tcec_top u_dut (.mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .agent0_bl_credit_taken(a0_bl_tk),
    .agent0_bl_credit_held(a0_bl_hd), .agent1_ad_credit_taken(a1_ad_tk),
    .agent1_ad_credit_held(a1_ad_hd), .agent1_bl_credit_taken(a1_bl_tk),
    .count_overflow());
  tcec_mesh_stop_model u_far (.mclk(mclk), .resetn(resetn), .max_mode(max_mode),
    .a0_bl_tk(a0_bl_tk), .a0_bl_hd(a0_bl_hd), .a1_ad_tk(a1_ad_tk), .a1_ad_hd(a1_ad_hd),
    .a1_bl_tk(a1_bl_tk));

  function automatic logic [31:0] xs();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction

  function automatic logic [47:0] f_inc(input logic [7:0] code, input logic [7:0] m);
    logic [47:0]      s;
    logic [16*AW-1:0] tv;
    logic [16*OW-1:0] hv;
    s  = 48'h0;
    tv = code[3] ? (code[2] ? a1_bl_tk : a0_bl_tk) : a1_ad_tk;
    hv = code[3] ? a0_bl_hd : a1_ad_hd;
    if (code < 8'h84 || code > 8'h8D)
      m = 8'h00;
    for (int i = 0; i < 8; i++)
      if (m[i])
        s += code[1] ? hv[(i + 8 * code[0]) * OW +: OW] : tv[(i + 8 * code[0]) * AW +: AW];
    return s;
  endfunction

  // ------------------------------------------------------------------
  // expected count, following the bus writes
  // ------------------------------------------------------------------
  always @(posedge mclk) begin
    if (wacc && paddr == `TCEC_ADDR_CTRL_LO)
      ctl <= pwdata;
    if (wacc && paddr == `TCEC_ADDR_CTRL_HI)
      xsel <= pwdata[`TCEC_XSEL_BIT];
    if (psel && !penable && paddr == `TCEC_ADDR_COUNT_LO)
      snap <= exp_cnt;
    if (wacc && paddr == `TCEC_ADDR_CTRL_LO && pwdata[`TCEC_CLR_BIT])
      exp_cnt <= 48'h0; // clear beats this edge's increment
    else if (ctl[`TCEC_EN_BIT] && xsel)
      exp_cnt <= exp_cnt + f_inc(ctl[7:0], ctl[15:8]);
  end

  task automatic results();
    $display("comparisons %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [47:0] got, input logic [47:0] want);
    n_tests++;
    if (got !== want) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      errors++;
      results();
    end
  endtask

  initial begin
    repeat (12) @(posedge mclk);
    resetn <= 1'b1;
    for (int k = 0; k < 5; k++) begin
      apb(1'b0, 12'(k * 4), 32'h0);
      chk(q, 48'h0);
    end
    apb(1'b0, 12'h014, 32'h0);
    chk({e, q}, {1'b1, 32'h0});
    apb(1'b0, 12'h002, 32'h0);
    chk({e, q}, {1'b1, 32'h0});
    apb(1'b1, `TCEC_ADDR_COUNT_LO, 32'hFFFFFFFF);
    chk(e, 1'b0);
    for (int p = 0; p < 2; p++) begin
      max_mode <= p[0];
      for (int i = 0; i < 12; i++) begin
        x = xs();
        um = (x[21:20] == 2'h0) ? 8'h00 : x[7:0];
        // random lanes differ, so the top-bit mapping is visible here
        if (codes[i] == 8'h8C)
          um = 8'hC0;
        apb(1'b1, `TCEC_ADDR_CTRL_HI,
            {7'h00, x[11:10] != 2'h0 || p == 1 || codes[i] == 8'h8C, 24'h0});
        apb(1'b1, `TCEC_ADDR_CTRL_LO,
            {9'h000, x[13:12] != 2'h0 || p == 1 || codes[i] == 8'h8C, 4'h0, 1'b1, 1'b0, um,
             codes[i]});
        apb(1'b0, `TCEC_ADDR_CTRL_LO, 32'h0);
        chk(q, ctl & `TCEC_CTRL_LO_WMASK);
        repeat (x[19:16] + 4) @(posedge mclk);
        repeat (2) begin
          apb(1'b0, `TCEC_ADDR_COUNT_LO, 32'h0);
          chk(q, snap[31:0]);
        end
        apb(1'b0, `TCEC_ADDR_COUNT_HI, 32'h0);
        chk(q, snap[47:32]);
        apb(1'b0, `TCEC_ADDR_STATUS, 32'h0);
        chk(q, {ctl[`TCEC_EN_BIT] && xsel && ctl[7:0] inside {[8'h84:8'h8D]}, 1'b0});
      end
    end
    results();
  end
endmodule // test_transgress_credit_event_count
`default_nettype wire
